// ===== rtl/pcat_top.sv
// counter array: shared 16-bit counter, timebase and 16-bit pwm modules
`timescale 1ns/100ps
module pcat_top #(
  parameter int NUM_MODS = 2
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // special function register port
  input  wire logic [7:0]          sfr_addr,
  input  wire logic [7:0]          sfr_wdata,
  input  wire logic                sfr_wr,
  output logic      [7:0]          sfr_rdata,
  // system events and count inputs
  input  wire logic                cpu_idle,
  input  wire logic                timer0_ovf,
  input  wire logic                external_count_input,
  input  wire logic                external_clock_in,
  // outputs
  output logic      [NUM_MODS-1:0] module_output_pin,
  output logic                     irq
);

  // ===========================================
  // elaboration check
  if (NUM_MODS < 1 || NUM_MODS > pcat_pkg::MAX_MODS) begin : g_bad
    $error("NUM_MODS out of range");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int i);
    hit = (a == (base + 8'(i)));
  endfunction

  // ===========================================
  // state
  logic [7:0]          mode_q, mode_d;
  logic                run_q, run_d;
  logic                cf_q, cf_d;
  logic [NUM_MODS-1:0] ccf_q, ccf_d;
  logic [7:0]          mmode_q [NUM_MODS];
  logic [7:0]          mmode_d [NUM_MODS];
  logic [15:0]         cmp_q [NUM_MODS];
  logic [15:0]         cmp_d [NUM_MODS];
  logic [15:0]         cnt_q, cnt_d;
  logic [NUM_MODS-1:0] pin_q, pin_d;
  logic                irq_q, irq_d;
  logic [7:0]          rdata_q, rdata_d;
  logic [3:0]          pre_q, pre_d;
  logic [2:0]          ediv_q, ediv_d;
  logic [2:0]          eci_q, eci_d;
  logic [2:0]          eclk_q, eclk_d;

  // ===========================================
  // timebase
  logic     running;
  logic     tick;
  pcat_pkg::pcat_tb_t tb;

  always_comb begin
    tb      = pcat_pkg::pcat_tb_t'(mode_q[pcat_pkg::TB_LSB +: 3]);
    running = run_q && !(mode_q[pcat_pkg::IDLE_BIT] && cpu_idle);
    // synchronisers: only stage 2 and 3 (bits 1 and 2) feed the edge logic
    eci_d   = {eci_q[1:0], external_count_input};
    eclk_d  = {eclk_q[1:0], external_clock_in};
    pre_d   = (pre_q == pcat_pkg::DIV12_LAST) ? 4'h0 : pre_q + 4'h1;
    ediv_d  = ediv_q;
    if (eclk_q[1] && !eclk_q[2]) begin
      ediv_d = ediv_q + 3'h1;
    end
    tick = 1'b0;
    case (tb)
      pcat_pkg::PCAT_TB_DIV12: tick = (pre_q == pcat_pkg::DIV12_LAST);
      pcat_pkg::PCAT_TB_DIV4:  tick = (pre_q[1:0] == pcat_pkg::DIV4_LAST);
      pcat_pkg::PCAT_TB_T0OVF: tick = timer0_ovf;
      pcat_pkg::PCAT_TB_ECI:   tick = !eci_q[1] && eci_q[2];
      pcat_pkg::PCAT_TB_SYS:   tick = 1'b1;
      pcat_pkg::PCAT_TB_EXT8:  tick = eclk_q[1] && !eclk_q[2]
                                      && (ediv_q == pcat_pkg::EXT_DIV_LAST);
      default:                 tick = 1'b0;
    endcase
    tick = tick && running;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pre_q  <= 4'h0;
      ediv_q <= 3'h0;
      eci_q  <= 3'h0;
      eclk_q <= 3'h0;
    end else begin
      pre_q  <= pre_d;
      ediv_q <= ediv_d;
      eci_q  <= eci_d;
      eclk_q <= eclk_d;
    end
  end

  // ===========================================
  // registers, counter and pwm
  logic        wr_ctrl;
  logic        wrap;
  logic [15:0] cnt_inc;

  always_comb begin
    wr_ctrl = sfr_wr && (sfr_addr == pcat_pkg::CTRL_ADDR);
    mode_d  = mode_q;
    run_d   = run_q;
    cf_d    = cf_q;
    ccf_d   = ccf_q;
    pin_d   = pin_q;
    cnt_d   = cnt_q;
    cnt_inc = cnt_q + 16'h0001;
    wrap    = tick && (cnt_q == pcat_pkg::CNT_LAST);
    if (sfr_wr && sfr_addr == pcat_pkg::MODE_ADDR) begin
      mode_d = sfr_wdata & pcat_pkg::MODE_MASK;
    end
    if (wr_ctrl) begin
      run_d = sfr_wdata[pcat_pkg::RUN_BIT];
      cf_d  = sfr_wdata[pcat_pkg::CF_BIT];
      ccf_d = sfr_wdata[NUM_MODS-1:0];
    end
    if (tick) begin
      cnt_d = cnt_inc;
    end
    if (wrap) begin
      cf_d = 1'b1;
    end
    for (int i = 0; i < NUM_MODS; i++) begin
      mmode_d[i] = mmode_q[i];
      cmp_d[i]   = cmp_q[i];
      if (sfr_wr && hit(sfr_addr, pcat_pkg::MMODE_BASE, i)) begin
        mmode_d[i] = sfr_wdata & pcat_pkg::MMODE_MASK;
      end
      if (sfr_wr && hit(sfr_addr, pcat_pkg::CPL_BASE, i)) begin
        cmp_d[i][7:0]                  = sfr_wdata;
        mmode_d[i][pcat_pkg::CMPEN_BIT] = 1'b0;
      end
      if (sfr_wr && hit(sfr_addr, pcat_pkg::CPH_BASE, i)) begin
        cmp_d[i][15:8]                 = sfr_wdata;
        mmode_d[i][pcat_pkg::CMPEN_BIT] = 1'b1;
      end
      if (mmode_q[i][pcat_pkg::CMPEN_BIT] && mmode_q[i][pcat_pkg::PWMEN_BIT]
          && mmode_q[i][pcat_pkg::WIDE_BIT]) begin
        if (wrap) begin
          pin_d[i] = 1'b0;
        end
        // match after overflow so a zero compare gives full duty
        if (tick && cnt_inc == cmp_q[i]) begin
          pin_d[i] = 1'b1;
          ccf_d[i] = 1'b1;
        end
      end else begin
        pin_d[i] = 1'b0;
      end
    end
    irq_d = (cf_d && mode_d[pcat_pkg::OVF_IE_BIT]);
    for (int i = 0; i < NUM_MODS; i++) begin
      irq_d = irq_d || (ccf_d[i] && mmode_d[i][pcat_pkg::MIE_BIT]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_q <= pcat_pkg::MODE_RESET;
      run_q  <= 1'b0;
      cf_q   <= 1'b0;
      ccf_q  <= '0;
      cnt_q  <= 16'h0000;
      pin_q  <= '0;
      irq_q  <= 1'b0;
      for (int i = 0; i < NUM_MODS; i++) begin
        mmode_q[i] <= pcat_pkg::MMODE_RESET;
        cmp_q[i]   <= 16'h0000;
      end
    end else begin
      mode_q <= mode_d;
      run_q  <= run_d;
      cf_q   <= cf_d;
      ccf_q  <= ccf_d;
      cnt_q  <= cnt_d;
      pin_q  <= pin_d;
      irq_q  <= irq_d;
      for (int i = 0; i < NUM_MODS; i++) begin
        mmode_q[i] <= mmode_d[i];
        cmp_q[i]   <= cmp_d[i];
      end
    end
  end

  // ===========================================
  // read data
  always_comb begin
    rdata_d = 8'h00;
    if (sfr_addr == pcat_pkg::MODE_ADDR) begin
      rdata_d = mode_q;
    end else if (sfr_addr == pcat_pkg::CTRL_ADDR) begin
      rdata_d = {cf_q, run_q, 6'h00};
      rdata_d[NUM_MODS-1:0] = ccf_q;
    end else if (sfr_addr == pcat_pkg::CNTL_ADDR) begin
      rdata_d = cnt_q[7:0];
    end else if (sfr_addr == pcat_pkg::CNTH_ADDR) begin
      rdata_d = cnt_q[15:8];
    end
    for (int i = 0; i < NUM_MODS; i++) begin
      if (hit(sfr_addr, pcat_pkg::MMODE_BASE, i)) begin
        rdata_d = mmode_q[i];
      end else if (hit(sfr_addr, pcat_pkg::CPL_BASE, i)) begin
        rdata_d = cmp_q[i][7:0];
      end else if (hit(sfr_addr, pcat_pkg::CPH_BASE, i)) begin
        rdata_d = cmp_q[i][15:8];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata         = rdata_q;
  assign module_output_pin = pin_q;
  assign irq               = irq_q;

  // ===========================================
  // assertions on module 0, the shared counter and the timebase
  logic wide0;
  assign wide0 = mmode_q[0][pcat_pkg::CMPEN_BIT] && mmode_q[0][pcat_pkg::PWMEN_BIT]
                 && mmode_q[0][pcat_pkg::WIDE_BIT];

  property p_match_high;
    @(posedge sys_clk) disable iff (reset)
      wide0 && tick && (cnt_inc == cmp_q[0]) |=> module_output_pin[0] && ccf_q[0];
  endproperty
  a_match_high: assert property (p_match_high) else $error("match did not raise pin");

  property p_ovf_low;
    @(posedge sys_clk) disable iff (reset)
      wide0 && wrap && (cmp_q[0] != 16'h0000) |=> !module_output_pin[0];
  endproperty
  a_ovf_low: assert property (p_ovf_low) else $error("overflow did not lower pin");

  property p_pwm_off;
    @(posedge sys_clk) disable iff (reset)
      !mmode_q[0][pcat_pkg::PWMEN_BIT] |=> !module_output_pin[0];
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pin high outside pwm mode");

  property p_low_clear;
    @(posedge sys_clk) disable iff (reset)
      sfr_wr && sfr_addr == pcat_pkg::CPL_BASE |=> !mmode_q[0][pcat_pkg::CMPEN_BIT];
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low byte kept enable");

  property p_high_set;
    @(posedge sys_clk) disable iff (reset)
      sfr_wr && sfr_addr == pcat_pkg::CPH_BASE |=> mmode_q[0][pcat_pkg::CMPEN_BIT];
  endproperty
  a_high_set: assert property (p_high_set) else $error("high byte did not enable");

  property p_idle_hold;
    @(posedge sys_clk) disable iff (reset)
      cpu_idle && mode_q[pcat_pkg::IDLE_BIT] && !(sfr_wr && sfr_addr == pcat_pkg::MODE_ADDR)
      |=> cnt_q == $past(cnt_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("counter ran in idle");

  property p_sys_count;
    @(posedge sys_clk) disable iff (reset)
      run_q && !cpu_idle && mode_q[3:1] == 3'b100 |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_sys_count: assert property (p_sys_count) else $error("system clock count missed");

  property p_ovf_irq;
    @(posedge sys_clk) disable iff (reset)
      wrap ##1 mode_q[pcat_pkg::OVF_IE_BIT] |-> cf_q && irq;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request missing");

  property p_mode_zero;
    @(posedge sys_clk) disable iff (reset)
      1'b1 |-> ##1 mode_q[6:4] == 3'b000;
  endproperty
  a_mode_zero: assert property (p_mode_zero) else $error("unused mode bits set");

  property p_match_irq;
    @(posedge sys_clk) disable iff (reset)
      wide0 && mmode_q[0][pcat_pkg::MIE_BIT] && !sfr_wr && tick && (cnt_inc == cmp_q[0])
      |=> irq;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("match request missing");

  property p_eci_tick;
    @(posedge sys_clk) disable iff (reset)
      running && tb == pcat_pkg::PCAT_TB_ECI && !eci_q[1] && eci_q[2]
      |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_eci_tick: assert property (p_eci_tick) else $error("falling edge not counted");

  property p_ext_hold;
    @(posedge sys_clk) disable iff (reset)
      tb == pcat_pkg::PCAT_TB_EXT8 && ediv_q != pcat_pkg::EXT_DIV_LAST
      |=> cnt_q == $past(cnt_q);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("external clock not divided");

endmodule

// ===== rtl/pcat_pkg.sv
// constants for the counter array with 16-bit pwm modules
// Overview of operation
// - compare value sets low time per period
// - match drives module output high
// - counter overflow drives module output low
// - pwm needs compare, pwm and wide enables
// - low compare byte write clears compare enable
// - high compare byte write sets compare enable
// - duty equals (65536 minus compare)/65536
// - match interrupt raised when enabled
// - idle suspend bit halts counting in idle
// - timebase field selects counter clock source
// - count falling edges, source max clock/4
// - external clock/8 resynchronised to system clock
// - overflow interrupt enable masks overflow request
// - unused mode bits read zero
package pcat_pkg;
  // register addresses
  localparam logic [7:0] CTRL_ADDR    = 8'hd8;
  localparam logic [7:0] MODE_ADDR    = 8'hd9;
  localparam logic [7:0] MMODE_BASE   = 8'hda;
  localparam logic [7:0] CNTL_ADDR    = 8'he9;
  localparam logic [7:0] CNTH_ADDR    = 8'hf9;
  localparam logic [7:0] CPL_BASE     = 8'hea;
  localparam logic [7:0] CPH_BASE     = 8'hfa;
  localparam int         MAX_MODS     = 6;
  // counter mode register fields
  localparam int         IDLE_BIT     = 7;
  localparam int         TB_LSB       = 1;
  localparam int         OVF_IE_BIT   = 0;
  localparam logic [7:0] MODE_MASK    = 8'h8f;
  localparam logic [7:0] MODE_RESET   = 8'h00;
  // counter control register fields
  localparam int         CF_BIT       = 7;
  localparam int         RUN_BIT      = 6;
  // module mode register fields
  localparam int         WIDE_BIT     = 7;
  localparam int         CMPEN_BIT    = 6;
  localparam int         PWMEN_BIT    = 1;
  localparam int         MIE_BIT      = 0;
  localparam logic [7:0] MMODE_MASK   = 8'hc3;
  localparam logic [7:0] MMODE_RESET  = 8'h00;
  // prescaler and counter last counts
  localparam logic [3:0] DIV12_LAST   = 4'hb;
  localparam logic [1:0] DIV4_LAST    = 2'h3;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;
  localparam logic [15:0] CNT_LAST    = 16'hffff;

  typedef enum logic [2:0] {
    PCAT_TB_DIV12 = 3'b000,
    PCAT_TB_DIV4  = 3'b001,
    PCAT_TB_T0OVF = 3'b010,
    PCAT_TB_ECI   = 3'b011,
    PCAT_TB_SYS   = 3'b100,
    PCAT_TB_EXT8  = 3'b101,
    PCAT_TB_RSV6  = 3'b110,
    PCAT_TB_RSV7  = 3'b111
  } pcat_tb_t;
endpackage

// ===== test/pcat_top_tb.sv
// self-checking bench for the counter array with 16-bit pwm modules
`timescale 1ns/100ps
module pcat_top_tb;
  logic       sys_clk;
  logic       reset;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic       sfr_wr;
  logic [7:0] sfr_rdata;
  logic       cpu_idle;
  logic       timer0_ovf;
  logic       external_count_input;
  logic       external_clock_in;
  logic [1:0] module_output_pin;
  logic       irq;
  int         n_errors;
  int         checks;
  int         hi0;
  int         hi1;
  logic [7:0] v;
  logic [15:0] cmp_v;
  localparam logic [7:0] TB_DELTA [8] = '{8'h04, 8'h0c, 8'h05, 8'h05, 8'h30, 8'h02, 8'h00, 8'h00};

  pcat_top #(.NUM_MODS(2)) pcat_top_i (
    .sys_clk              (sys_clk),
    .reset                (reset),
    .sfr_addr             (sfr_addr),
    .sfr_wdata            (sfr_wdata),
    .sfr_wr               (sfr_wr),
    .sfr_rdata            (sfr_rdata),
    .cpu_idle             (cpu_idle),
    .timer0_ovf           (timer0_ovf),
    .external_count_input (external_count_input),
    .external_clock_in    (external_clock_in),
    .module_output_pin    (module_output_pin),
    .irq                  (irq)
  );

  // ==========================================
  // clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (80000) @(posedge sys_clk);
    n_errors++;
    end_of_test();
  end

  // ==========================================
  // access tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    sfr_addr = a;
    @(negedge sys_clk);
    d = sfr_rdata;
  endtask

  task automatic irq_after(input logic [7:0] a, input logic [7:0] d, input logic e);
    wr(a, d);
    repeat (2) @(negedge sys_clk);
    chk("irq", 16'(irq), 16'(e));
  endtask

  // one timer 0 overflow pulse, outputs settled on return
  task automatic t0_pulse();
    @(negedge sys_clk);
    timer0_ovf = 1'b1;
    @(negedge sys_clk);
    timer0_ovf = 1'b0;
  endtask

  // counter ticks over 48 cycles, with events made for the chosen timebase
  task automatic delta(input logic [7:0] mode, input logic [7:0] exp);
    logic [7:0] v0;
    logic [7:0] v1;
    wr(pcat_pkg::MODE_ADDR, mode);
    sfr_addr = pcat_pkg::CNTL_ADDR;
    repeat (2) @(negedge sys_clk);
    v0 = sfr_rdata;
    for (int i = 0; i < 48; i++) begin
      @(negedge sys_clk);
      timer0_ovf = (mode[3:1] == 3'b010) && (i < 10) && !i[0];
      external_count_input = (mode[3:1] == 3'b011 && i < 20) ? i[1] : 1'b1;
      external_clock_in = (mode[3:1] == 3'b101 && i < 32) ? i[0] : 1'b0;
    end
    v1 = sfr_rdata - v0;
    chk("counter_delta", 16'(v1), 16'(exp));
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================
  // tests
  initial begin
    n_errors = 0;
    checks = 0;
    reset = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    cpu_idle = 1'b0;
    timer0_ovf = 1'b0;
    external_count_input = 1'b1;
    external_clock_in = 1'b0;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    rd(pcat_pkg::MODE_ADDR, v);
    chk("mode_reset", 16'(v), 16'(pcat_pkg::MODE_RESET));
    wr(pcat_pkg::MODE_ADDR, 8'hff);
    rd(pcat_pkg::MODE_ADDR, v);
    chk("mode_unused", 16'(v), 16'h008f);
    rd(8'h00, v);
    chk("unmapped", 16'(v), 16'h0000);
    wr(pcat_pkg::MMODE_BASE, 8'hc2);
    wr(pcat_pkg::CPL_BASE, 8'h00);
    rd(pcat_pkg::MMODE_BASE, v);
    chk("low_byte_clears", 16'(v), 16'h0082);
    wr(pcat_pkg::CPH_BASE, 8'hff);
    rd(pcat_pkg::MMODE_BASE, v);
    chk("high_byte_sets", 16'(v), 16'h00c2);
    // module 1 lacks the wide select
    wr(pcat_pkg::MMODE_BASE + 8'h01, 8'h42);
    wr(pcat_pkg::CPL_BASE + 8'h01, 8'h00);
    wr(pcat_pkg::CPH_BASE + 8'h01, 8'h80);
    wr(pcat_pkg::MODE_ADDR, 8'h08);
    wr(pcat_pkg::CTRL_ADDR, 8'h40);
    hi0 = 0;
    hi1 = 0;
    repeat (65546) begin
      @(negedge sys_clk);
      if (module_output_pin[0] === 1'b1) hi0++;
      if (module_output_pin[1] === 1'b1) hi1++;
    end
    chk("pwm_high_cycles", 16'(hi0), 16'h0100);
    chk("pin_low_after_wrap", 16'(module_output_pin[0]), 16'h0000);
    chk("pin_not_pwm", 16'(hi1), 16'h0000);
    rd(pcat_pkg::CTRL_ADDR, v);
    chk("flags", 16'(v), 16'h00c1);
    irq_after(pcat_pkg::MMODE_BASE, 8'hc2, 1'b0);
    irq_after(pcat_pkg::MODE_ADDR, 8'h09, 1'b1);
    irq_after(pcat_pkg::MODE_ADDR, 8'h08, 1'b0);
    irq_after(pcat_pkg::MMODE_BASE, 8'hc3, 1'b1);
    irq_after(pcat_pkg::CTRL_ADDR, 8'h40, 1'b0);
    for (int s = 0; s < 8; s++) begin
      delta({4'h0, 3'(s), 1'b0}, TB_DELTA[s]);
    end
    cpu_idle = 1'b1;
    delta(8'h88, 8'h00);
    delta(8'h08, 8'h30);
    cpu_idle = 1'b0;
    // counter stepped by timer 0 pulses, compare reloaded after the match request
    wr(pcat_pkg::MODE_ADDR, 8'h04);
    rd(pcat_pkg::CNTL_ADDR, cmp_v[7:0]);
    rd(pcat_pkg::CNTH_ADDR, cmp_v[15:8]);
    cmp_v = cmp_v + 16'h0002;
    wr(pcat_pkg::CPL_BASE, cmp_v[7:0]);
    wr(pcat_pkg::CPH_BASE, cmp_v[15:8]);
    wr(pcat_pkg::CTRL_ADDR, 8'h40);
    t0_pulse();
    chk("irq_before_match", 16'(irq), 16'h0000);
    t0_pulse();
    chk("match_irq", 16'(irq), 16'h0001);
    chk("match_pin", 16'(module_output_pin[0]), 16'h0001);
    cmp_v = cmp_v + 16'h0002;
    wr(pcat_pkg::CPL_BASE, cmp_v[7:0]);
    wr(pcat_pkg::CPH_BASE, cmp_v[15:8]);
    wr(pcat_pkg::CTRL_ADDR, 8'h40);
    t0_pulse();
    chk("irq_after_reload", 16'(irq), 16'h0000);
    t0_pulse();
    chk("reload_match_irq", 16'(irq), 16'h0001);
    end_of_test();
  end
endmodule
